// file: verilog/reset_controller.sv
/*
  reset controller: collects reset requests, holds the device in reset,
  times the internal initialisation and keeps sticky cause flags.
  assumes nrst_i is the power-on detector and the apb master is on clk_i.
*/
// Added by the designer: the APB register port.
// What this block does
// - cause flags latch until software writes one
// - after power-on only power-on flag set
// - power-on clears all flags but its own
// - six flags at bits 5..0, rest zero
// - no other flag before first boot completes
// - writing go bit starts reset two cycles later
// - software reset holds until sequence completes
// - unkeyed writes accepted but change nothing
// - enabled pin holds reset while low
// - pin and watchdog spare debug, timer, brownout
// - debug reset only from debugger, spares debug
// - power-on resets all, no timer override
// - brownout resets all but brownout configuration
// - fuse registers reload after each reset
// - initialisation 250 us plus startup fuse time
// - memory scan adds 500 us per kilobyte
// - runs in active and every sleep mode
// - pin and brownout need fuse enable once fuses load, watchdog and debug never gated
// - go bit always reads zero
`timescale 1ns/1ps
`default_nettype none

module reset_controller
  import reset_source_pkg::*;
#(
  parameter int         INIT_US    = INIT_TIME_US,
  parameter int         SUT_US     = SUT_STEP_US,
  parameter int         US_CYCLES  = CYCLES_PER_US,
  parameter logic [7:0] KEY_VALUE  = 8'h5A // arbitrary key value
) (
  // clock and power-on reset
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // reset sources
  input  wire logic        bod_req_i,
  input  wire logic        ext_rst_pin_n_i,
  input  wire logic        wdt_req_i,
  input  wire logic        dbg_req_i,
  input  wire logic        cpu_instr_i,
  // fuses
  input  wire logic        fuse_ext_en_i,
  input  wire logic        fuse_bod_en_i,
  input  wire logic [2:0]  fuse_sut_i,
  input  wire logic [7:0]  fuse_crc_kb_i,
  // reset domains and status
  output logic             core_rst_o,
  output logic             debug_rst_o,
  output logic             tcd_ovr_rst_o,
  output logic             bod_cfg_rst_o,
  output logic             tcd_ovr_avail_o,
  output logic             fuse_reload_o,
  output logic             boot_done_o
);

  typedef struct packed {
    seq_state_type st;
    logic [31:0]   us_left;
    logic [5:0]    flags;
    logic          sw_hold;
    logic [2:0]    key_win;
    logic          boot_seen;
    logic          por_boot;
    logic          bod_seq;
    logic          ext_en;
    logic          bod_en;
    logic [2:0]    startup_time_fuse;
    logic [7:0]    crc_kb;
    logic          reload;
    logic [31:0]   rdata;
    logic          slverr;
  } ctl_type;

  localparam ctl_type CTL_RESET = '{
    st: ST_HOLD, us_left: '0, flags: FLAGS_AFTER_POR, sw_hold: 1'b0,
    key_win: '0, boot_seen: 1'b0, por_boot: 1'b1, bod_seq: 1'b0,
    ext_en: 1'b1, bod_en: 1'b1, startup_time_fuse: '0, crc_kb: '0, reload: 1'b0,
    rdata: '0, slverr: 1'b0};

  ctl_type q;
  ctl_type d;

  logic        pin_n_sync;
  logic        bod_sync;
  logic        tick;
  logic [5:0]  req;
  logic [5:0]  flag_clr;
  logic        any_req;
  logic        any_ext;
  logic        setup;
  logic        wr;
  logic [31:0] init_load;

  function automatic logic reg_hit(input logic [7:0] a,
                                   input logic [5:0] idx);
    reg_hit = (a[7:2] == idx) && (a[1:0] == 2'b00);
  endfunction : reg_hit

  // ==========================================================
  // input crossing and time base
  // ==========================================================
  sync_two_ff #(.WIDTH(2), .RST_VAL(2'b01)) u_sync (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .async_i ({bod_req_i, ext_rst_pin_n_i}),
    .sync_o  ({bod_sync, pin_n_sync})
  );

  tick_divider #(.DIV(US_CYCLES)) u_tick (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .tick_o (tick)
  );

  // ==========================================================
  // request collection
  // ==========================================================
  always_comb begin
    req = '0;
    req[FLG_BROWNOUT] = q.bod_en & bod_sync;
    req[FLG_PIN]      = q.ext_en & ~pin_n_sync;
    req[FLG_WATCHDOG] = wdt_req_i;
    req[FLG_SOFT]     = q.sw_hold;
    req[FLG_DEBUG]    = dbg_req_i;
  end

  assign any_req   = |req;
  assign any_ext   = |(req & ~(6'h01 << FLG_SOFT));
  assign setup     = psel_i & ~penable_i;
  assign wr        = psel_i & penable_i & pwrite_i;
  assign flag_clr  = (wr && reg_hit(paddr_i, IDX_FLAGS)) ?
                     pwdata_i[5:0] : '0;
  assign init_load = 32'(INIT_US)
                   + 32'(fuse_sut_i) * 32'(SUT_US)
                   + 32'(fuse_crc_kb_i) * 32'(CRC_US_PER_KB);

  // ==========================================================
  // next state
  // ==========================================================
  always_comb begin
    d = q;
    d.reload = 1'b0;
    // key window counts cpu instructions
    if (cpu_instr_i && (q.key_win != '0)) begin
      d.key_win = q.key_win - 3'h1;
    end
    if (wr && reg_hit(paddr_i, IDX_KEY) &&
        (pwdata_i[7:0] == KEY_VALUE)) begin
      d.key_win = KEY_WINDOW_INSTR;
    end
    // unkeyed writes are taken and dropped
    if (wr && reg_hit(paddr_i, IDX_SW_TRIG) && (q.key_win != '0)) begin
      d.key_win = '0;
      if (pwdata_i[SOFT_RESET_GO]) begin
        d.sw_hold = 1'b1;
      end
    end
    // sticky flags, set wins over clear
    d.flags = (q.flags & ~flag_clr)
            | (q.boot_seen ? req : 6'h00);
    if (req[FLG_BROWNOUT]) begin
      d.bod_seq = 1'b1;
    end
    // sequencer, never gated by sleep state
    case (q.st)
      ST_HOLD: begin
        if (!any_ext) begin
          d.st      = ST_INIT;
          d.us_left = init_load;
          d.sw_hold = 1'b0;
          d.reload  = 1'b1;
          d.ext_en  = fuse_ext_en_i;
          d.bod_en  = fuse_bod_en_i;
          d.startup_time_fuse     = fuse_sut_i;
          d.crc_kb  = fuse_crc_kb_i;
        end
      end
      ST_INIT: begin
        if (any_req) begin
          d.st = ST_HOLD;
        end else if (q.us_left == '0) begin
          d.st        = ST_RUN;
          d.boot_seen = 1'b1;
          d.por_boot  = 1'b0;
          d.bod_seq   = 1'b0;
        end else if (tick) begin
          d.us_left = q.us_left - 32'h0000_0001;
        end
      end
      ST_RUN: begin
        if (any_req) begin
          d.st = ST_HOLD;
        end
      end
      default: begin
        d.st = ST_HOLD;
      end
    endcase
    // apb read data captured in the setup cycle
    if (setup) begin
      d.slverr = 1'b0;
      if (reg_hit(paddr_i, IDX_FLAGS)) begin
        d.rdata = {26'h000_0000, q.flags};
      end else if (reg_hit(paddr_i, IDX_SW_TRIG)) begin
        d.rdata = '0;
      end else if (reg_hit(paddr_i, IDX_KEY)) begin
        d.rdata = {29'h0000_0000, q.key_win};
      end else if (reg_hit(paddr_i, IDX_FUSE_VIEW)) begin
        d.rdata = {19'h0_0000, q.ext_en, q.bod_en, q.startup_time_fuse, q.crc_kb};
      end else begin
        d.rdata  = '0;
        d.slverr = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= CTL_RESET;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs
  // ==========================================================
  assign prdata_o        = q.rdata;
  assign pready_o        = 1'b1;
  assign pslverr_o       = q.slverr & psel_i & penable_i;
  assign core_rst_o      = (q.st != ST_RUN);
  assign debug_rst_o     = core_rst_o & (q.por_boot | q.bod_seq);
  assign tcd_ovr_rst_o   = core_rst_o & (q.por_boot | q.bod_seq);
  assign bod_cfg_rst_o   = core_rst_o & q.por_boot;
  assign tcd_ovr_avail_o = ~q.por_boot;
  assign fuse_reload_o   = q.reload;
  assign boot_done_o     = (q.st == ST_RUN);

  // ==========================================================
  // checks
  // ==========================================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  a_flags_sticky: assert property (
    1 |=> (($past(q.flags) & ~$past(flag_clr) & ~q.flags) == 6'h00))
    else $error("latched flag lost without clear");

  a_no_early_flag: assert property (
    !q.boot_seen |-> (q.flags[5:1] == 5'h00))
    else $error("flag set before first boot");

  a_soft_go: assert property (
    (wr && reg_hit(paddr_i, IDX_SW_TRIG) && pwdata_i[SOFT_RESET_GO]
     && q.key_win != '0 && q.st == ST_RUN)
    |=> q.sw_hold ##1 (core_rst_o && q.st == ST_HOLD))
    else $error("software reset did not start");

  a_unkeyed_drop: assert property (
    (wr && reg_hit(paddr_i, IDX_SW_TRIG) && q.key_win == '0
     && q.st == ST_RUN) |=> $stable(q.sw_hold))
    else $error("unkeyed write changed register");

  a_pin_holds: assert property (
    (q.ext_en && !pin_n_sync) |=> (q.st == ST_HOLD) && core_rst_o)
    else $error("low pin did not hold reset");

  a_init_load: assert property (
    (q.st == ST_HOLD && !any_ext) |=>
    (q.st == ST_INIT && q.us_left == $past(init_load) && fuse_reload_o))
    else $error("init time or reload wrong");

  a_run_release: assert property (
    (q.st == ST_RUN && any_req) |=> core_rst_o [*2])
    else $error("active source did not hold reset");

  a_user_domains: assert property (
    (core_rst_o && !q.por_boot && !q.bod_seq && !req[FLG_BROWNOUT])
    |-> (!debug_rst_o && !tcd_ovr_rst_o && !bod_cfg_rst_o))
    else $error("user reset hit spared domains");

  a_bod_domains: assert property (
    (core_rst_o && q.bod_seq && !q.por_boot)
    |-> (debug_rst_o && tcd_ovr_rst_o && !bod_cfg_rst_o))
    else $error("brownout domains wrong");

  a_go_reads_zero: assert property (
    (setup && reg_hit(paddr_i, IDX_SW_TRIG)) |=> (prdata_o == 32'h0000_0000))
    else $error("go bit read nonzero");

  a_por_override: assert property (
    q.por_boot |-> (!tcd_ovr_avail_o && bod_cfg_rst_o && core_rst_o))
    else $error("override available during power-on");

  c_first_boot: cover property ($rose(boot_done_o));
  c_soft_cycle: cover property (q.sw_hold ##[1:20] (q.st == ST_INIT));
  c_flag_clear: cover property ((flag_clr != 6'h00) ##1 (q.flags == 6'h00));
  c_pin_reset: cover property (q.st == ST_RUN && req[FLG_PIN]);
  c_bod_reset: cover property (q.st == ST_RUN && req[FLG_BROWNOUT]);

endmodule : reset_controller

`default_nettype wire

// file: verilog/reset_source_pkg.sv
/*
  constants, register map and state type of the reset source controller.
  assumes a 20 mhz peripheral clock and apb register access.
*/
`default_nettype none

package reset_source_pkg;

  // ==========================================================
  // register indices, byte address is four times the index
  // ==========================================================
  localparam logic [5:0] IDX_FLAGS     = 6'h00;
  localparam logic [5:0] IDX_SW_TRIG   = 6'h01;
  localparam logic [5:0] IDX_KEY       = 6'h02;
  localparam logic [5:0] IDX_FUSE_VIEW = 6'h03;

  // ==========================================================
  // flag layout
  // ==========================================================
  localparam int         NUM_FLAGS        = 6;
  localparam int         FLG_POWER_ON     = 0;
  localparam int         FLG_BROWNOUT     = 1;
  localparam int         FLG_PIN          = 2;
  localparam int         FLG_WATCHDOG     = 3;
  localparam int         FLG_SOFT         = 4;
  localparam int         FLG_DEBUG        = 5;
  localparam logic [5:0] FLAGS_AFTER_POR  = 6'h01;
  localparam int         SOFT_RESET_GO    = 0;

  // ==========================================================
  // timing
  // ==========================================================
  localparam int CLK_HZ           = 20000000;
  localparam int HZ_PER_MHZ       = 1000000;
  localparam int CYCLES_PER_US    = CLK_HZ / HZ_PER_MHZ;
  localparam int INIT_TIME_US     = 250;
  localparam int CRC_US_PER_KB    = 500;
  localparam int SUT_STEP_US      = 1000;
  localparam logic [2:0] KEY_WINDOW_INSTR = 3'h4;

  // ==========================================================
  // sequencer states
  // ==========================================================
  typedef enum logic [1:0] {
    ST_HOLD,
    ST_INIT,
    ST_RUN
  } seq_state_type;

endpackage : reset_source_pkg

`default_nettype wire

// file: verilog/sync_two_ff.sv
/*
  two flip-flop synchroniser for a group of level inputs.
  assumes inputs change slowly against clk_i.
*/
`timescale 1ns/1ps
`default_nettype none

module sync_two_ff #(
  parameter int         WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  // levels
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_type;

  sync_type q;
  sync_type d;

  // ==========================================================
  // two stages
  // ==========================================================
  always_comb begin
    d.meta   = async_i;
    d.stable = q.meta;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= {RST_VAL, RST_VAL};
    end else begin
      q <= d;
    end
  end

  assign sync_o = q.stable;

endmodule : sync_two_ff

`default_nettype wire

// file: verilog/tick_divider.sv
/*
  divider giving a one-cycle enable pulse every DIV cycles.
  assumes DIV of at least one.
*/
`timescale 1ns/1ps
`default_nettype none

module tick_divider #(
  parameter int DIV = 20
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic nrst_i,
  // enable pulse
  output logic      tick_o
);

  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } div_type;

  localparam logic [15:0] LAST = 16'(DIV - 1);

  div_type q;
  div_type d;

  // ==========================================================
  // count and wrap
  // ==========================================================
  always_comb begin
    d = q;
    d.tick = (q.cnt == LAST);
    d.cnt  = (q.cnt == LAST) ? '0 : q.cnt + 16'h0001;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick_o = q.tick;

endmodule : tick_divider

`default_nettype wire

// file: tb/reset_source_model.sv
/*
  reset source model: brownout, pin, watchdog and debugger requests.
  assumes one request at a time, held for len_i cycles after go_i.
*/
`timescale 1ns/1ps
`default_nettype none

module reset_source_model (
  // control from the bench
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [1:0] which_i,
  input  wire logic [7:0] len_i,
  // requests towards the controller, busy flag to the bench
  output logic            bod_req_o,
  output logic            ext_rst_pin_n_o,
  output logic            wdt_req_o,
  output logic            dbg_req_o,
  output logic            busy_o
);
  // ==========================================================
  // request timing
  // ==========================================================
  logic [7:0] left_q = 8'h00;
  logic [1:0] src_q  = 2'h0;

  always @(posedge clk_i) begin
    if (go_i) begin
      left_q <= len_i;
      src_q  <= which_i;
    end else if (left_q != 8'h00) begin
      left_q <= left_q - 8'h01;
    end
  end

  assign busy_o          = (left_q != 8'h00);
  assign bod_req_o       = busy_o && (src_q == 2'h0);
  assign ext_rst_pin_n_o = !(busy_o && (src_q == 2'h1));
  assign wdt_req_o       = busy_o && (src_q == 2'h2);
  assign dbg_req_o       = busy_o && (src_q == 2'h3);
endmodule : reset_source_model

`default_nettype wire

// file: tb/reset_source_controller_bench.sv
/*
  self-checking bench of the reset controller, flags modelled in integers.
  assumes the package, the design and the source model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module reset_source_controller_bench;
  import reset_source_pkg::*;

  // ==========================================================
  // settings and signals
  // ==========================================================
  localparam int         INIT = 2;
  localparam int         SUTU = 1;
  localparam int         USC  = 2;
  localparam logic [7:0] KEY  = 8'h5A;
  logic        clk_i  = 1'b0;
  logic        nrst_i = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        go = 1'b0, cpu_instr = 1'b0, ext_en = 1'b1;
  logic [1:0]  which = 2'h0;
  logic [2:0]  startup_time_fuse = 3'h0;
  logic [7:0]  paddr = 8'h00, len = 8'h00, kb = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        bod_req, pin_n, wdt_req, dbg_req, busy, pready, pslverr;
  logic        core_rst, dbg_rst, tcd_rst, bod_rst, avail, reload, done;
  logic [31:0] prdata, rd;
  logic        er;
  logic [15:0] seed = 16'h1155;
  int          bad_count = 0, checks_done = 0, exp_flags = 1, cyc;
  int          srcs[$] = '{FLG_BROWNOUT, FLG_PIN, FLG_WATCHDOG, FLG_DEBUG};

  reset_controller #(.INIT_US(INIT), .SUT_US(SUTU), .US_CYCLES(USC),
    .KEY_VALUE(KEY)) i_reset_controller (
    .clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .bod_req_i(bod_req), .ext_rst_pin_n_i(pin_n), .wdt_req_i(wdt_req),
    .dbg_req_i(dbg_req), .cpu_instr_i(cpu_instr), .fuse_ext_en_i(ext_en),
    .fuse_bod_en_i(1'b1), .fuse_sut_i(startup_time_fuse), .fuse_crc_kb_i(kb),
    .core_rst_o(core_rst), .debug_rst_o(dbg_rst), .tcd_ovr_rst_o(tcd_rst),
    .bod_cfg_rst_o(bod_rst), .tcd_ovr_avail_o(avail),
    .fuse_reload_o(reload), .boot_done_o(done));

  reset_source_model i_reset_source_model (
    .clk_i(clk_i), .go_i(go), .which_i(which), .len_i(len),
    .bod_req_o(bod_req), .ext_rst_pin_n_o(pin_n), .wdt_req_o(wdt_req),
    .dbg_req_o(dbg_req), .busy_o(busy));

  // ==========================================================
  // helpers
  // ==========================================================
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  function automatic int init_cyc(input int s, input int k);
    return (INIT + s * SUTU + k * CRC_US_PER_KB) * USC;
  endfunction : init_cyc

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic chk_rng(input string nm, input int e, input int g);
    checks_done++;
    if (g < e - USC - 1 || g > e + USC + 1) begin
      bad_count++;
      $display("unexpected %s: expected %0d seen %0d", nm, e, g);
    end
  endtask : chk_rng

  task automatic apb(input logic w, input logic [5:0] idx,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) bad_count++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic fire(input logic [1:0] w, input logic [7:0] l);
    @(posedge clk_i);
    go <= 1'b1;
    which <= w;
    len <= l;
    @(posedge clk_i);
    go <= 1'b0;
  endtask : fire

  task automatic wait_rst();
    int n;
    n = 0;
    while (core_rst !== 1'b1 && n < 6) begin
      @(negedge clk_i);
      n++;
    end
  endtask : wait_rst

  task automatic boot();
    int n;
    n = 0;
    cyc = 0;
    while (reload !== 1'b1 && n < 4000) begin
      @(negedge clk_i);
      n++;
    end
    while (done !== 1'b1 && n < 4000) begin
      @(negedge clk_i);
      n++;
      cyc++;
    end
    if (n >= 4000) bad_count++;
  endtask : boot

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize

  // ==========================================================
  // clock and watchdog
  // ==========================================================
  initial begin
    forever #25 clk_i = ~clk_i;
  end

  initial begin
    #1_000_000;
    bad_count++;
    summarize();
  end

  // ==========================================================
  // tests
  // ==========================================================
  initial begin
    repeat (20) @(posedge clk_i);
    nrst_i <= 1'b1;
    chk("avail", 0, avail);
    repeat (3) @(posedge clk_i);
    fire(2'd2, 8'd1);
    boot();
    apb(0, IDX_FLAGS, 0);
    chk("flags", exp_flags, rd);
    chk("avail", 1, avail);
    $display("test power_on done");
    seed = lfsr(seed);
    apb(1, IDX_FLAGS, {16'h0000, seed});
    exp_flags = exp_flags & ~int'(seed);
    apb(0, IDX_FLAGS, 0);
    chk("flags", exp_flags, rd);
    apb(1, IDX_FLAGS, 32'h0000_00FF);
    exp_flags = 0;
    apb(1, IDX_SW_TRIG, 32'h0000_0001);
    repeat (4) @(negedge clk_i);
    chk("core_rst", 0, core_rst);
    apb(0, IDX_SW_TRIG, 0);
    chk("trigger", 0, rd);
    apb(1, IDX_KEY, {24'h00_0000, KEY});
    repeat (5) @(posedge clk_i) cpu_instr <= 1'b1;
    @(posedge clk_i) cpu_instr <= 1'b0;
    apb(1, IDX_SW_TRIG, 32'h0000_0001);
    repeat (4) @(negedge clk_i);
    chk("core_rst", 0, core_rst);
    apb(1, 6'h08, 32'h0000_003F);
    chk("pslverr", 1, er);
    apb(0, IDX_FLAGS, 0);
    chk("flags", exp_flags, rd);
    $display("test protection done");
    apb(1, IDX_KEY, {24'h00_0000, KEY});
    apb(1, IDX_SW_TRIG, 32'h0000_0001);
    wait_rst();
    chk("core_rst", 1, core_rst);
    chk("debug_rst", 0, dbg_rst);
    boot();
    chk_rng("init_cycles", init_cyc(0, 0), cyc);
    exp_flags |= 1 << FLG_SOFT;
    apb(0, IDX_FLAGS, 0);
    chk("flags", exp_flags, rd);
    $display("test soft_reset done");
    foreach (srcs[i]) begin
      startup_time_fuse <= 3'(i);
      kb <= 8'(i == 3);
      if (i == 2) ext_en <= 1'b0;
      seed = lfsr(seed);
      fire(2'(i), 8'd3 + 8'(seed[2:0]));
      wait_rst();
      chk("core_rst", 1, core_rst);
      chk("debug_rst", 32'(i == 0), dbg_rst);
      chk("tcd_rst", 32'(i == 0), tcd_rst);
      chk("bod_cfg_rst", 0, bod_rst);
      boot();
      chk_rng("init_cycles", init_cyc(i, i == 3), cyc);
      exp_flags |= 1 << srcs[i];
      apb(0, IDX_FLAGS, 0);
      chk("flags", exp_flags, rd);
    end
    fire(2'd1, 8'd6);
    repeat (10) @(negedge clk_i);
    chk("core_rst", 0, core_rst);
    $display("test sources done");
    fire(2'd2, 8'd2);
    wait_rst();
    boot();
    @(posedge clk_i) nrst_i <= 1'b0;
    @(negedge clk_i);
    chk("debug_rst", 1, dbg_rst);
    chk("avail", 0, avail);
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    exp_flags = 1;
    boot();
    apb(0, IDX_FLAGS, 0);
    chk("flags", exp_flags, rd);
    $display("test second_power_on done");
    summarize();
  end
endmodule : reset_source_controller_bench

`default_nettype wire
